// ===== rtl/operating_mode_select.sv
/*
  Operating mode selection: strap capture, mode decode, port steering,
  narrow-bus splitting, debug state and debug ROM decode, serial access.
  Assumes strap pins are asynchronous and all other inputs are on clk.
*/
// What this block does
// - Decode {debug pin, B, A} into seven modes; 110 forced to peripheral.
// - Latch the three strap levels at reset release as the mode status bits.
// - Pull up the debug pin and pull down both mode pins during reset.
// - Open strap pins decode to normal single-chip.
// - Wide expanded: port A high addr/data, port B low addr/data.
// - Narrow expanded: port A high addr with 8-bit data, port B low addr.
// - Normal single-chip: A, B, E are GPIO; E1..E0 input-only with pullups.
// - At reset port E pullups on, port A and B pullups off.
// - Special wide: all port E bus-control pins take bus-control function.
// - Narrow mode: 16-bit transfer is two byte cycles, high then low.
// - Special single-chip: no reset vector fetch, debug active at once.
// - Special single-chip: no external bus, ports are GPIO.
// - Peripheral mode: processor idle, external master drives the bus.
// - No runtime mode change into or out of peripheral mode.
// - Outside special single-chip, debug must be enabled before activation.
// - Enabled debug activates on serial command or entry instruction.
// - Active debug maps $FF00-$FFFF to debug ROM, registers $FF00-$FF06.
// - Active debug: ROM supplies vectors, top user memory hidden from CPU.
// - Serial accesses use idle cycles; nonvolatile memory is read only.
// - Normal modes write-protect control bits; special modes allow more.
// - Mode B/A writable once if negated bit is 1, anytime if 0.
`timescale 1ns/1ps
module operating_mode_select
  import opmode_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic debug_serial_pin_in,
  input wire logic mode_select_b_in,
  input wire logic mode_select_a_in,
  output logic debug_pin_pullup_en,
  output logic mode_pins_pulldown_en,
  output logic mode_valid,
  output logic special_mode_negated_bit,
  output logic mode_select_b,
  output logic mode_select_a,
  output logic is_special,
  output logic is_expanded,
  output logic is_wide,
  output logic is_peripheral,
  output logic is_single_chip,
  output logic [1:0] porta_func,
  output logic [1:0] portb_func,
  output logic porte_bus_ctrl,
  output logic porte_low_input_pullup,
  output logic ports_gpio,
  input wire logic pull_wr,
  input wire logic [2:0] pull_wdata,
  output logic porte_pullup_en,
  output logic portb_pullup_en,
  output logic porta_pullup_en,
  output logic write_protect_en,
  input wire logic mode_wr,
  input wire logic [1:0] mode_wdata,
  output logic mode_wr_refused,
  output logic cpu_run_en,
  output logic reset_vector_fetch_en,
  input wire logic bdm_enable_cmd,
  input wire logic bdm_activate_cmd,
  input wire logic enter_debug_instruction,
  input wire logic bdm_exit_cmd,
  output logic debug_enabled,
  output logic background_debug_state,
  input wire logic [15:0] cpu_addr,
  output logic sel_debug_rom,
  output logic sel_debug_regs,
  output logic vectors_from_debug_rom,
  input wire logic ser_req,
  input wire logic ser_we,
  input wire logic ser_nvm,
  input wire logic cpu_bus_idle,
  output logic ser_grant,
  output logic ser_refused,
  input wire logic xfer_req,
  input wire logic xfer_we,
  input wire logic [15:0] xfer_addr,
  input wire logic [15:0] xfer_wdata,
  input wire logic [15:0] ext_rdata,
  output logic xfer_busy,
  output logic bus_cyc,
  output logic bus_we,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic xfer_done,
  output logic [15:0] xfer_rdata
);

  typedef enum logic {P_STRAP, P_RUN} phase_e;
  typedef enum logic [1:0] {X_IDLE, X_WIDE, X_HI, X_LO} xfer_e;

  logic [2:0] strap_sync_q;
  phase_e phase, next_phase;
  logic [1:0] settle, next_settle;
  logic [2:0] mode, next_mode;
  logic wr_ok;
  logic mode_written;
  logic wr_accept;

  // Pins may change right up to the release, so they are resynchronised first.
  strap_sync #(.WIDTH(3), .RST_VAL(STRAP_PULL_VAL)) u_strap_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({debug_serial_pin_in, mode_select_b_in, mode_select_a_in}),
    .q(strap_sync_q)
  );

  // A write may never land in or leave peripheral, nor pick the reserved code.
  always_comb begin
    wr_accept = (phase == P_RUN) && !is_peripheral && !(mode_wdata == 2'h2);
  end

  write_once_gate u_mode_gate (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_req(mode_wr),
    .once_only(mode[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT]),
    .accept(wr_accept),
    .wr_ok(wr_ok),
    .written(mode_written)
  );

  logic d_special, d_expanded, d_wide, d_periph, d_single;
  logic next_pull;
  logic [1:0] next_pa, next_pb;
  logic next_pe_bus, next_pe_low, next_gpio, next_refused;
  logic [2:0] next_pulls;

  always_comb begin
    next_phase = phase;
    next_settle = settle;
    next_mode = mode;
    if (phase == P_STRAP) begin
      next_settle = settle + 2'h1;
      if (settle == STRAP_SETTLE) begin
        next_phase = P_RUN;
        next_mode = strap_sync_q;
      end
    end else if (wr_ok) begin
      next_mode = {mode[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT], mode_wdata};
    end
    next_pull = (next_phase == P_STRAP);
    next_refused = mode_wr && !wr_ok;
    // Code 110 (reserved) decodes as peripheral, hence special as well.
    d_periph = next_mode[STRAP_B_BIT] && !next_mode[STRAP_A_BIT];
    d_special = !next_mode[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT] || d_periph;
    d_expanded = next_mode[STRAP_A_BIT];
    d_wide = next_mode[STRAP_B_BIT] && next_mode[STRAP_A_BIT];
    d_single = !next_mode[STRAP_B_BIT] && !next_mode[STRAP_A_BIT];
    next_pa = PORT_GPIO;
    next_pb = PORT_GPIO;
    if (d_periph) begin
      next_pa = PORT_EXT_MASTER;
      next_pb = PORT_EXT_MASTER;
    end else if (d_wide) begin
      next_pa = PORT_ADDR_DATA;
      next_pb = PORT_ADDR_DATA;
    end else if (d_expanded) begin
      next_pa = PORT_ADDR_NARROW;
      next_pb = PORT_ADDR_NARROW;
    end
    next_pe_bus = d_expanded;
    next_pe_low = d_single;
    next_gpio = d_single;
    next_pulls = {porte_pullup_en, portb_pullup_en, porta_pullup_en};
    if (pull_wr) begin
      next_pulls = pull_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= P_STRAP;
      settle <= 2'h0;
      mode <= STRAP_PULL_VAL;
      mode_valid <= 1'b0;
      debug_pin_pullup_en <= 1'b1;
      mode_pins_pulldown_en <= 1'b1;
      is_special <= 1'b0;
      is_expanded <= 1'b0;
      is_wide <= 1'b0;
      is_peripheral <= 1'b0;
      is_single_chip <= 1'b1;
      porta_func <= PORT_GPIO;
      portb_func <= PORT_GPIO;
      porte_bus_ctrl <= 1'b0;
      porte_low_input_pullup <= 1'b1;
      ports_gpio <= 1'b1;
      porte_pullup_en <= PORTE_PULLUP_RST;
      portb_pullup_en <= PORTB_PULLUP_RST;
      porta_pullup_en <= PORTA_PULLUP_RST;
      mode_wr_refused <= 1'b0;
    end else begin
      phase <= next_phase;
      settle <= next_settle;
      mode <= next_mode;
      mode_valid <= (next_phase == P_RUN);
      debug_pin_pullup_en <= next_pull;
      mode_pins_pulldown_en <= next_pull;
      is_special <= d_special;
      is_expanded <= d_expanded;
      is_wide <= d_wide;
      is_peripheral <= d_periph;
      is_single_chip <= d_single;
      porta_func <= next_pa;
      portb_func <= next_pb;
      porte_bus_ctrl <= next_pe_bus;
      porte_low_input_pullup <= next_pe_low;
      ports_gpio <= next_gpio;
      {porte_pullup_en, portb_pullup_en, porta_pullup_en} <= next_pulls;
      mode_wr_refused <= next_refused;
    end
  end

  always_comb begin
    special_mode_negated_bit = mode[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT];
    mode_select_b = mode[STRAP_B_BIT];
    mode_select_a = mode[STRAP_A_BIT];
  end

  // Debug state, CPU run control and debug ROM decode.
  logic next_dbg_en, next_dbg_act, ssc_at_start;
  logic next_run, next_vec, next_rom, next_regs;
  logic next_wp;

  always_comb begin
    ssc_at_start = (phase == P_STRAP) && (next_phase == P_RUN) && (next_mode == 3'h0);
    next_dbg_en = debug_enabled || bdm_enable_cmd;
    next_dbg_act = background_debug_state;
    if (bdm_exit_cmd) begin
      next_dbg_act = 1'b0;
    end
    // Activation wins over a simultaneous exit so a trigger is never lost.
    if (debug_enabled && (bdm_activate_cmd || enter_debug_instruction)) begin
      next_dbg_act = 1'b1;
    end
    if (ssc_at_start) begin
      next_dbg_en = 1'b1;
      next_dbg_act = 1'b1;
    end
    next_run = (next_phase == P_RUN) && !d_periph;
    next_vec = (next_phase == P_RUN) && !d_periph && !ssc_at_start
               && !(mode == 3'h0 && phase == P_RUN);
    next_rom = next_dbg_act && (cpu_addr[15:8] == DEBUG_ROM_PAGE);
    next_regs = next_dbg_act && (cpu_addr >= DEBUG_REG_FIRST)
                && (cpu_addr <= DEBUG_REG_LAST);
    next_wp = next_mode[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT] && !d_periph;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      debug_enabled <= 1'b0;
      background_debug_state <= 1'b0;
      cpu_run_en <= 1'b0;
      reset_vector_fetch_en <= 1'b0;
      sel_debug_rom <= 1'b0;
      sel_debug_regs <= 1'b0;
      vectors_from_debug_rom <= 1'b0;
      write_protect_en <= 1'b1;
    end else begin
      debug_enabled <= next_dbg_en;
      background_debug_state <= next_dbg_act;
      cpu_run_en <= next_run;
      reset_vector_fetch_en <= next_vec;
      sel_debug_rom <= next_rom;
      sel_debug_regs <= next_regs;
      vectors_from_debug_rom <= next_dbg_act;
      write_protect_en <= next_wp;
    end
  end

  // Serial debug access: one request waits for an idle bus cycle.
  logic ser_pend, ser_we_q, ser_nvm_q, ser_serve;
  logic next_ser_pend, next_ser_we, next_ser_nvm, next_grant, next_sref;

  always_comb begin
    ser_serve = ser_pend && cpu_bus_idle;
    next_grant = ser_serve && !(ser_we_q && ser_nvm_q);
    next_sref = ser_serve && ser_we_q && ser_nvm_q;
    next_ser_pend = ser_pend && !ser_serve;
    next_ser_we = ser_we_q;
    next_ser_nvm = ser_nvm_q;
    if (ser_req) begin
      next_ser_pend = 1'b1;
      next_ser_we = ser_we;
      next_ser_nvm = ser_nvm;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_pend <= 1'b0;
      ser_we_q <= 1'b0;
      ser_nvm_q <= 1'b0;
      ser_grant <= 1'b0;
      ser_refused <= 1'b0;
    end else begin
      ser_pend <= next_ser_pend;
      ser_we_q <= next_ser_we;
      ser_nvm_q <= next_ser_nvm;
      ser_grant <= next_grant;
      ser_refused <= next_sref;
    end
  end

  // External transfer sequencer; a narrow bus takes two byte cycles.
  xfer_e xst, next_xst;
  logic [15:0] x_addr, next_x_addr, x_wdata, next_x_wdata, next_rdata;
  logic [15:0] next_baddr, next_bwdata;
  logic x_take, next_bcyc, next_bwe, next_done;

  always_comb begin
    x_take = (xst == X_IDLE) && xfer_req && mode_valid && is_expanded && !is_peripheral;
    next_xst = xst;
    next_x_addr = x_addr;
    next_x_wdata = x_wdata;
    next_rdata = xfer_rdata;
    next_baddr = bus_addr;
    next_bwdata = bus_wdata;
    next_bwe = bus_we;
    next_bcyc = 1'b0;
    next_done = 1'b0;
    unique case (xst)
      X_IDLE: begin
        if (x_take) begin
          next_x_addr = xfer_addr;
          next_x_wdata = xfer_wdata;
          next_bcyc = 1'b1;
          next_bwe = xfer_we;
          if (is_wide) begin
            next_xst = X_WIDE;
            next_baddr = xfer_addr;
            next_bwdata = xfer_wdata;
          end else begin
            next_xst = X_HI;
            next_baddr = {xfer_addr[15:1], 1'b0};
            next_bwdata = {8'h00, xfer_wdata[15:8]};
          end
        end
      end
      X_WIDE: begin
        next_rdata = ext_rdata;
        next_done = 1'b1;
        next_xst = X_IDLE;
      end
      X_HI: begin
        next_rdata = {ext_rdata[7:0], xfer_rdata[7:0]};
        next_bcyc = 1'b1;
        next_baddr = {x_addr[15:1], 1'b1};
        next_bwdata = {8'h00, x_wdata[7:0]};
        next_xst = X_LO;
      end
      X_LO: begin
        next_rdata = {xfer_rdata[15:8], ext_rdata[7:0]};
        next_done = 1'b1;
        next_xst = X_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xst <= X_IDLE;
      x_addr <= 16'h0000;
      x_wdata <= 16'h0000;
      xfer_rdata <= 16'h0000;
      bus_addr <= 16'h0000;
      bus_wdata <= 16'h0000;
      bus_we <= 1'b0;
      bus_cyc <= 1'b0;
      xfer_done <= 1'b0;
      xfer_busy <= 1'b0;
    end else begin
      xst <= next_xst;
      x_addr <= next_x_addr;
      x_wdata <= next_x_wdata;
      xfer_rdata <= next_rdata;
      bus_addr <= next_baddr;
      bus_wdata <= next_bwdata;
      bus_we <= next_bwe;
      bus_cyc <= next_bcyc;
      xfer_done <= next_done;
      xfer_busy <= (next_xst != X_IDLE);
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pulls_released: assert property (mode_valid |->
      !debug_pin_pullup_en && !mode_pins_pulldown_en)
    else $error("strap pulls still on after capture");
  a_capture_stable: assert property (mode_valid && $past(mode_valid) |->
      $stable(special_mode_negated_bit))
    else $error("special bit changed after capture");
  a_open_single_chip: assert property ($rose(mode_valid)
      && $past(strap_sync_q) == STRAP_PULL_VAL |-> !is_special && is_single_chip && ports_gpio)
    else $error("open straps did not give normal single chip");
  a_wide_ports: assert property (is_wide && !is_peripheral |->
      porta_func == PORT_ADDR_DATA && portb_func == PORT_ADDR_DATA)
    else $error("wide mode port function wrong");
  a_narrow_split: assert property (x_take && !is_wide |=>
      bus_cyc && !bus_addr[0] ##1 bus_cyc && bus_addr[0] ##1 xfer_done && !bus_cyc)
    else $error("narrow transfer not split high then low");
  a_ssc_debug: assert property ($rose(mode_valid) && mode == 3'h0 |->
      background_debug_state && !reset_vector_fetch_en)
    else $error("special single chip did not start in debug");
  a_debug_gate: assert property ($rose(background_debug_state) |->
      $past(debug_enabled) || $rose(mode_valid))
    else $error("debug became active without enable");
  a_rom_decode: assert property (sel_debug_rom |->
      background_debug_state && $past(cpu_addr[15:8]) == DEBUG_ROM_PAGE)
    else $error("debug ROM selected while debug inactive");
  a_nvm_readonly: assert property (ser_pend && ser_we_q && ser_nvm_q && cpu_bus_idle |=>
      ser_refused && !ser_grant)
    else $error("serial write to nonvolatile memory granted");
  a_periph_locked: assert property (mode_valid && $past(mode_valid) && $past(is_peripheral) |->
      is_peripheral && !cpu_run_en)
    else $error("peripheral mode left without reset");

  c_narrow_xfer: cover property (x_take && !is_wide ##3 xfer_done);
  c_enter_debug_instruction_entry: cover property (debug_enabled && enter_debug_instruction ##1 background_debug_state);
  c_mode_refused: cover property (mode_wr_refused);
  c_ser_grant: cover property (ser_grant);

endmodule

// ===== rtl/opmode_pkg.sv
/*
  Shared constants for the operating mode selection block: strap codes,
  port function codes, settle and address-window constants.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package opmode_pkg;

  // Strap word layout {debug_serial_pin, mode_select_b, mode_select_a}.
  localparam int STRAP_SPECIAL_MODE_NEGATED_BIT_BIT = 2;
  localparam int STRAP_B_BIT = 1;
  localparam int STRAP_A_BIT = 0;

  // Level the open pins settle to under the reset pulls (normal single chip).
  localparam logic [2:0] STRAP_PULL_VAL = 3'h4;

  // Clock edges after release that the synchronised straps need to settle.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Pull enables at reset.
  localparam logic PORTE_PULLUP_RST = 1'b1;
  localparam logic PORTA_PULLUP_RST = 1'b0;
  localparam logic PORTB_PULLUP_RST = 1'b0;

  // Port function codes.
  localparam logic [1:0] PORT_GPIO = 2'h0;
  localparam logic [1:0] PORT_ADDR_DATA = 2'h1;
  localparam logic [1:0] PORT_ADDR_NARROW = 2'h2;
  localparam logic [1:0] PORT_EXT_MASTER = 2'h3;

  // Debug ROM window and debug control register window.
  localparam logic [7:0] DEBUG_ROM_PAGE = 8'hff;
  localparam logic [15:0] DEBUG_REG_FIRST = 16'hff00;
  localparam logic [15:0] DEBUG_REG_LAST = 16'hff06;

endpackage

// ===== rtl/strap_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to clk; RST_VAL is the pulled level.
*/
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== rtl/write_once_gate.sv
/*
  Write gate for a protected field: once_only limits it to one accepted
  write after reset, otherwise any accepted write passes.
  Assumes wr_req is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module write_once_gate (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_req,
  input wire logic once_only,
  input wire logic accept,
  output logic wr_ok,
  output logic written
);
  logic next_written;

  always_comb begin
    wr_ok = wr_req && accept && !(once_only && written);
    next_written = written || wr_ok;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      written <= 1'b0;
    end else begin
      written <= next_written;
    end
  end
endmodule

// ===== tb/ext_bus_model.sv
/*
  External memory on the far side of the multiplexed address/data bus.
  Assumes bus_cyc and bus_addr come registered from the design on clk.
*/
`timescale 1ns/1ps
module ext_bus_model (
  input wire logic clk,
  input wire logic bus_cyc,
  input wire logic [15:0] bus_addr,
  output logic [15:0] ext_rdata
);
  logic [15:0] last = 16'h0000;
  // Released lines show the inverse of the last value, so a stale sample never matches.
  always @(posedge clk) begin
    last <= ext_rdata;
  end
  assign ext_rdata = bus_cyc ? ~bus_addr : ~last;
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for operating_mode_select with an external memory model.
  Assumes the bench drives the strap pins, or leaves them open on the reset pulls.
*/
`timescale 1ns/1ps
module tb_top;
  import opmode_pkg::*;
  typedef struct packed {logic [2:0] code; logic [14:0] flags; logic [14:0] mask;} row_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic open_pins = 1'b0;
  logic [2:0] strap = 3'h4;
  logic pull_wr = 1'b0, mode_wr = 1'b0, bdm_enable_cmd = 1'b0, bdm_activate_cmd = 1'b0;
  logic enter_debug_instruction = 1'b0, bdm_exit_cmd = 1'b0, ser_req = 1'b0, ser_we = 1'b0;
  logic ser_nvm = 1'b0, cpu_bus_idle = 1'b0, xfer_req = 1'b0, xfer_we = 1'b0;
  logic [2:0] pull_wdata = 3'h0;
  logic [1:0] mode_wdata = 2'h0;
  logic [15:0] cpu_addr = 16'h0000, xfer_addr = 16'h0000, xfer_wdata = 16'h0000;
  logic [15:0] ext_rdata, bus_addr, bus_wdata, xfer_rdata;
  logic [1:0] porta_func, portb_func;
  logic debug_pin_pullup_en, mode_pins_pulldown_en, mode_valid, special_mode_negated_bit;
  logic mode_select_b, mode_select_a, is_special, is_expanded, is_wide, is_peripheral;
  logic is_single_chip, porte_bus_ctrl, porte_low_input_pullup, ports_gpio, porte_pullup_en;
  logic portb_pullup_en, porta_pullup_en, write_protect_en, mode_wr_refused, cpu_run_en;
  logic reset_vector_fetch_en, debug_enabled, background_debug_state, sel_debug_rom;
  logic sel_debug_regs, vectors_from_debug_rom, ser_grant, ser_refused, xfer_busy, bus_cyc;
  logic bus_we, xfer_done;
  logic [15:0] seen_addr [2];
  logic [15:0] seen_wdata [2];
  int ncyc;
  int miscompares = 0;
  int comparisons = 0;
  // An open pin follows its pull while enabled and the inverse level afterwards.
  wire logic debug_serial_pin_in = open_pins ? debug_pin_pullup_en : strap[STRAP_SPECIAL_MODE_NEGATED_BIT_BIT];
  wire logic mode_select_b_in = open_pins ? ~mode_pins_pulldown_en : strap[STRAP_B_BIT];
  wire logic mode_select_a_in = open_pins ? ~mode_pins_pulldown_en : strap[STRAP_A_BIT];
  wire logic [2:0] mode_bits = {special_mode_negated_bit, mode_select_b, mode_select_a};
  wire logic [14:0] flags = {is_special, is_expanded, is_wide, is_peripheral, is_single_chip,
    porte_bus_ctrl, ports_gpio, cpu_run_en, reset_vector_fetch_en, background_debug_state,
    write_protect_en, porta_func, portb_func};
  row_s rows [8] = '{'{3'h0, 15'h45a0, 15'h7fff}, '{3'h1, 15'h62ca, 15'h7fff},
    '{3'h2, 15'h480f, 15'h4dbf}, '{3'h3, 15'h72c5, 15'h7fff}, '{3'h4, 15'h05d0, 15'h7fff},
    '{3'h5, 15'h22da, 15'h7fff}, '{3'h6, 15'h480f, 15'h4dbf}, '{3'h7, 15'h32d5, 15'h7fff}};

  operating_mode_select i_operating_mode_select (.clk, .sys_rst, .debug_serial_pin_in,
    .mode_select_b_in, .mode_select_a_in, .debug_pin_pullup_en, .mode_pins_pulldown_en,
    .mode_valid, .special_mode_negated_bit, .mode_select_b, .mode_select_a, .is_special,
    .is_expanded, .is_wide, .is_peripheral, .is_single_chip, .porta_func, .portb_func,
    .porte_bus_ctrl, .porte_low_input_pullup, .ports_gpio, .pull_wr, .pull_wdata,
    .porte_pullup_en, .portb_pullup_en, .porta_pullup_en, .write_protect_en, .mode_wr,
    .mode_wdata, .mode_wr_refused, .cpu_run_en, .reset_vector_fetch_en, .bdm_enable_cmd,
    .bdm_activate_cmd, .enter_debug_instruction, .bdm_exit_cmd, .debug_enabled,
    .background_debug_state, .cpu_addr, .sel_debug_rom, .sel_debug_regs,
    .vectors_from_debug_rom, .ser_req, .ser_we, .ser_nvm, .cpu_bus_idle, .ser_grant,
    .ser_refused, .xfer_req, .xfer_we, .xfer_addr, .xfer_wdata, .ext_rdata, .xfer_busy,
    .bus_cyc, .bus_we, .bus_addr, .bus_wdata, .xfer_done, .xfer_rdata);
  ext_bus_model i_ext_bus_model (.clk, .bus_cyc, .bus_addr, .ext_rdata);

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input string what);
    for (int n = 0; s !== 1'b1; n++) begin
      if (n > 8) begin
        chk(what, 16'h0001, 16'h0000);
        test_done();
      end
      step();
    end
  endtask
  task automatic boot(input logic [2:0] code);
    sys_rst = 1'b1;
    strap = code;
    repeat (4) step();
    sys_rst = 1'b0;
    wait_hi(mode_valid, "mode_valid");
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  task automatic mw(input logic [1:0] d, input logic refused, input logic [2:0] bits);
    mode_wdata = d;
    pulse(mode_wr);
    chk("mode_wr_refused", {15'h0, refused}, {15'h0, mode_wr_refused});
    chk("mode bits", {13'h0, bits}, {13'h0, mode_bits});
    step();
  endtask
  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d);
    seen_addr = '{default: 'x};
    seen_wdata = '{default: 'x};
    xfer_we = we;
    xfer_addr = a;
    xfer_wdata = d;
    pulse(xfer_req);
    ncyc = 0;
    for (int n = 0; n < 6 && xfer_done !== 1'b1; n++) begin
      if (bus_cyc === 1'b1 && ncyc < 2) begin
        chk("bus_we", {15'h0, we}, {15'h0, bus_we});
        chk("xfer_busy", 16'h0001, {15'h0, xfer_busy});
        seen_addr[ncyc] = bus_addr;
        seen_wdata[ncyc] = bus_wdata;
        ncyc++;
      end
      step();
    end
    // Only the expanded codes of the last boot may run a transfer to its end.
    chk("xfer_done", {15'h0, strap[STRAP_A_BIT]}, {15'h0, xfer_done});
    if (xfer_done !== strap[STRAP_A_BIT]) begin
      test_done();
    end
  endtask

  initial begin
    foreach (rows[i]) begin
      boot(rows[i].code);
      chk("mode bits", {13'h0, rows[i].code}, {13'h0, mode_bits});
      chk("mode flags", {1'b0, rows[i].flags}, {1'b0, flags & rows[i].mask});
      chk("flags again", {1'b0, rows[i].flags}, {1'b0, flags & rows[i].mask});
      step();
      chk("flags held", {1'b0, rows[i].flags}, {1'b0, flags & rows[i].mask});
    end
    $display("test mode table done");
    open_pins = 1'b1;
    sys_rst = 1'b1;
    step();
    chk("reset pulls", 16'h001c, {11'h0, debug_pin_pullup_en, mode_pins_pulldown_en,
      porte_pullup_en, portb_pullup_en, porta_pullup_en});
    boot(3'h0);
    chk("open mode", 16'h05d4, {1'b0, flags} ^ {13'h0, mode_bits});
    chk("port e pullups", 16'h0001, {15'h0, porte_low_input_pullup});
    open_pins = 1'b0;
    pull_wdata = 3'h3;
    pulse(pull_wr);
    chk("pull write", 16'h0003, {13'h0, porte_pullup_en, portb_pullup_en, porta_pullup_en});
    $display("test open pins done");
    mw(2'h1, 1'b0, 3'h5);
    chk("expanded after write", 16'h0001, {15'h0, is_expanded});
    mw(2'h3, 1'b1, 3'h5);
    boot(3'h0);
    mw(2'h2, 1'b1, 3'h0);
    mw(2'h3, 1'b0, 3'h3);
    mw(2'h1, 1'b0, 3'h1);
    boot(3'h2);
    mw(2'h3, 1'b1, 3'h2);
    $display("test mode write done");
    // Debug triggers are only sent outside peripheral mode.
    boot(3'h4);
    pulse(enter_debug_instruction);
    chk("debug before enable", 16'h0000, {15'h0, background_debug_state});
    pulse(bdm_enable_cmd);
    chk("debug enabled", 16'h0001, {15'h0, debug_enabled});
    pulse(bdm_activate_cmd);
    chk("debug by command", 16'h0001, {15'h0, background_debug_state});
    foreach (seen_addr[i]) begin
      cpu_addr = i ? 16'hff07 : 16'hff03;
      step();
      chk("debug decode", i ? 16'h0005 : 16'h0007,
        {13'h0, sel_debug_rom, sel_debug_regs, vectors_from_debug_rom});
    end
    pulse(bdm_exit_cmd);
    cpu_addr = 16'hff03;
    step();
    chk("decode after exit", 16'h0000, {13'h0, sel_debug_rom, sel_debug_regs,
      vectors_from_debug_rom});
    pulse(enter_debug_instruction);
    chk("debug by instruction", 16'h0001, {15'h0, background_debug_state});
    $display("test debug done");
    pulse(ser_req);
    repeat (3) begin
      chk("grant while busy", 16'h0000, {15'h0, ser_grant});
      step();
    end
    cpu_bus_idle = 1'b1;
    wait_hi(ser_grant, "ser_grant");
    step();
    ser_we = 1'b1;
    ser_nvm = 1'b1;
    pulse(ser_req);
    wait_hi(ser_refused, "ser_refused");
    $display("test serial done");
    boot(3'h7);
    xfer(1'b0, 16'h1234, 16'h0000);
    chk("wide read", 16'hedcb, xfer_rdata);
    chk("wide cycle", 16'h1235, seen_addr[0] + ncyc[15:0]);
    xfer(1'b1, 16'h2000, 16'habcd);
    chk("wide write", 16'habcd, seen_wdata[0]);
    boot(3'h5);
    xfer(1'b0, 16'h1234, 16'h0000);
    chk("narrow read", 16'hcbca, xfer_rdata);
    chk("narrow odd cycle", 16'h1235, seen_addr[1]);
    xfer(1'b1, 16'h2000, 16'habcd);
    chk("narrow high first", 16'h00ab, seen_wdata[0]);
    chk("narrow low next", 16'h00cd, seen_wdata[1]);
    boot(3'h0);
    xfer(1'b0, 16'h1234, 16'h0000);
    chk("single chip bus", 16'h0000, ncyc[15:0]);
    $display("test transfer done");
    test_done();
  end
endmodule
